// ==== rtl/bwp_pkg.sv ====
package bwp_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CACHE_LINE_LENGTH      = 8'h0C;
  localparam logic [7:0] OFS_CHIP_BEHAVIOUR_CONTROL = 8'h40;
  localparam logic [7:0] OFS_READ_FETCH_CONTROL     = 8'h44;
  localparam logic [7:0] OFS_POLICY_STATUS          = 8'h48;
  localparam logic [7:0] OFS_PREFETCH_COUNT         = 8'h4C;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         CBC_WR_DISC_BIT      = 0;
  localparam int         RFC_DN_CL_PF_BIT     = 1;
  localparam int         RFC_UP_CL_PF_BIT     = 2;
  localparam int         RFC_UP_PF_DIS_BIT    = 3;
  localparam int         RFC_DN_MPC_LSB       = 4;
  localparam int         RFC_UP_MPC_LSB       = 6;
  localparam logic [7:0] RST_CACHE_LINE_LENGTH = 8'h00;
  localparam logic [7:0] RST_CHIP_BEHAVIOUR    = 8'h00;
  localparam logic [7:0] RST_READ_FETCH        = 8'h06;

  // ---------------------------------------------------------------
  // sizes and limits, in dwords
  // ---------------------------------------------------------------
  localparam logic [10:0] DW_PER_4K        = 11'h400;
  localparam logic [10:0] MIN_PREFETCH_DW  = 11'h010;
  localparam logic [10:0] MWI_ROOM_DW      = 11'h008;
  localparam logic [10:0] ALIGN16_DW       = 11'h010;

  // ---------------------------------------------------------------
  // bus commands
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_IO_READ   = 4'h2;
  localparam logic [3:0] CMD_IO_WRITE  = 4'h3;
  localparam logic [3:0] CMD_MEM_READ  = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] CMD_CFG_READ  = 4'hA;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hB;
  localparam logic [3:0] CMD_MEM_RMULT = 4'hC;
  localparam logic [3:0] CMD_MEM_RLINE = 4'hE;
  localparam logic [3:0] CMD_MEM_WINV  = 4'hF;

  typedef enum logic [1:0] {
    BWP_IDLE,
    BWP_WRITE,
    BWP_READ
  } bwp_phase_t;

  // per data phase view of the target side of the bus
  typedef struct packed {
    logic        start;      // address phase of a new transaction
    logic [3:0]  cmd;
    logic [31:0] addr;
    logic        upstream;   // request came from the secondary side
    logic        fast_b2b;   // started with no idle cycle before it
    logic        in_pref_range;
    logic        single_dw;  // initiator asks for one dword only
    logic        phase;      // one data phase completes this cycle
    logic        last;       // initiator ends with this phase
  } bwp_txn_t;

  // buffer and target-side status
  typedef struct packed {
    logic [10:0] pw_free_dw;   // free posted write data dwords
    logic        dq_free;      // delayed queue has an open entry
    logic        rd_fifo_full;
    logic        tgt_disc;     // target side disconnected the read
    logic        rd_taken;     // initiator pulls prefetched data
    logic        single_req;   // one request pending in buffers
  } bwp_buf_t;

  // decisions towards the target state machine
  typedef struct packed {
    logic        disconnect;   // stop with this data phase
    logic        retry;        // terminate without taking data
    logic        accept;
    logic        prefetch;     // read classified prefetchable
    logic        all_be;       // drive all byte enables on later phases
    logic        fetch_go;     // keep issuing read phases
    logic        discard;      // drop unconsumed prefetched data
    logic        flow;         // read runs in flow-through
    logic [10:0] pf_count;
  } bwp_ctl_t;

endpackage : bwp_pkg

// ==== rtl/bwp_policy.sv ====
module bwp_policy
  import bwp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic      [1:0]        avs_response,
  input  wire bwp_txn_t          txn,
  input  wire bwp_buf_t          buf_st,
  output bwp_ctl_t               ctl
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  cache_line_size;
    logic [7:0]  cbc;
    logic [7:0]  rfc;
    logic        ack;
    logic [31:0] rdata;
    logic [1:0]  resp;
    bwp_phase_t  phase;
    logic [3:0]  cmd;
    logic        mwi_ok;
    logic        upstream;
    logic [31:0] addr;      // dword address of the next phase
    logic [10:0] line_cnt;  // dwords inside the current line
    logic [10:0] fetched;
    bwp_ctl_t    ctl;
  } bwp_state_t;

  bwp_state_t s_q;
  bwp_state_t s_d;

  // ---------------------------------------------------------------
  // combinational helpers
  // ---------------------------------------------------------------
  logic        cls_pow2;
  logic        cls_small;
  logic [10:0] cls_dw;
  logic [1:0]  max_prefetch_count;
  logic        mpc_en;
  logic [10:0] base_cnt;
  logic [10:0] cache_line_boundary_count;
  logic [10:0] calc_cnt;
  logic        is_read;
  logic        is_pref;
  logic        wr_boundary;
  logic        at_4k;
  logic        at_line;
  logic        at_16;
  logic        stop_ev;

  always_comb begin
    // line size is a dword count; legal for MWI only as a power of two up to 16
    cls_pow2  = (s_q.cache_line_size == 8'h01) || (s_q.cache_line_size == 8'h02) || (s_q.cache_line_size == 8'h04)
             || (s_q.cache_line_size == 8'h08) || (s_q.cache_line_size == 8'h10);
    cls_small = cls_pow2 && (s_q.cache_line_size != 8'h10);
    cls_dw    = {3'h0, s_q.cache_line_size};
    // the count is only latched at the address phase, so it reads the request itself
    max_prefetch_count       = txn.upstream ? s_q.rfc[RFC_UP_MPC_LSB +: 2] : s_q.rfc[RFC_DN_MPC_LSB +: 2];
    mpc_en    = !s_q.rfc[RFC_DN_CL_PF_BIT] && !s_q.rfc[RFC_UP_CL_PF_BIT];
    // dwords left to the next line boundary, or 16 when the line size is not a power of two
    cache_line_boundary_count   = cls_pow2 ? (cls_dw - (txn.addr[12:2] & (cls_dw - 11'h001))) : ALIGN16_DW;
    base_cnt  = 11'({9'h0, max_prefetch_count} * cls_dw);
    if (!mpc_en || ({3'h0, max_prefetch_count} < s_q.cache_line_size)) begin
      calc_cnt = cache_line_boundary_count;
    end else begin
      calc_cnt = base_cnt + cache_line_boundary_count;
    end
    if (calc_cnt < MIN_PREFETCH_DW) begin
      calc_cnt = MIN_PREFETCH_DW;
    end
    is_read = (txn.cmd == CMD_IO_READ) || (txn.cmd == CMD_CFG_READ)
           || (txn.cmd == CMD_MEM_READ) || (txn.cmd == CMD_MEM_RLINE)
           || (txn.cmd == CMD_MEM_RMULT);
    is_pref = ((txn.cmd == CMD_MEM_RLINE) || (txn.cmd == CMD_MEM_RMULT))
           || ((txn.cmd == CMD_MEM_READ) && (txn.upstream
               ? !s_q.rfc[RFC_UP_PF_DIS_BIT] : txn.in_pref_range));
    at_4k   = (s_q.addr[9:0] == 10'h3FF);
    at_16   = (s_q.addr[3:0] == 4'hF);
    at_line = cls_pow2 && (s_q.line_cnt == cls_dw - 11'h001);
    wr_boundary = 1'b0;
    if (s_q.cmd == CMD_MEM_WINV && s_q.mwi_ok) begin
      wr_boundary = at_4k
                 || (s_q.cache_line_size == 8'h10 && at_16)
                 || (cls_small && at_line && buf_st.pw_free_dw < MWI_ROOM_DW);
    end else if (s_q.cbc[CBC_WR_DISC_BIT]) begin
      wr_boundary = at_line || at_4k;
    end else begin
      wr_boundary = at_4k;
    end
    stop_ev = txn.last || buf_st.rd_fifo_full || at_4k || buf_st.tgt_disc;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ctl.disconnect = 1'b0;
    s_d.ctl.retry      = 1'b0;
    s_d.ctl.accept     = 1'b0;
    s_d.ctl.discard    = 1'b0;
    s_d.ack            = 1'b0;

    // register slave: one wait cycle, answer on the second edge
    if ((avs_read || avs_write) && !s_q.ack) begin
      s_d.ack   = 1'b1;
      s_d.rdata = 32'h0000_0000;
      s_d.resp  = 2'h0;
      if (avs_address == OFS_CACHE_LINE_LENGTH) begin
        s_d.rdata = {24'h0, s_q.cache_line_size};
      end else if (avs_address == OFS_CHIP_BEHAVIOUR_CONTROL) begin
        s_d.rdata = {24'h0, s_q.cbc};
      end else if (avs_address == OFS_READ_FETCH_CONTROL) begin
        s_d.rdata = {24'h0, s_q.rfc};
      end else if (avs_address == OFS_POLICY_STATUS) begin
        s_d.rdata = {26'h0, s_q.ctl.fetch_go, s_q.ctl.flow, s_q.ctl.prefetch, s_q.mwi_ok,
                     s_q.phase};
      end else if (avs_address == OFS_PREFETCH_COUNT) begin
        s_d.rdata = {10'h0, s_q.fetched, s_q.ctl.pf_count};
      end else begin
        s_d.resp = 2'h2; // unmapped: slave error
      end
    end

    // a write lands only on the edge where the master sees waitrequest low
    if (avs_write && s_q.ack && avs_byteenable[0]) begin
      if (avs_address == OFS_CACHE_LINE_LENGTH) begin
        s_d.cache_line_size = avs_writedata[7:0];
      end else if (avs_address == OFS_CHIP_BEHAVIOUR_CONTROL) begin
        s_d.cbc = avs_writedata[7:0];
      end else if (avs_address == OFS_READ_FETCH_CONTROL) begin
        s_d.rfc = avs_writedata[7:0];
      end
    end

    case (s_q.phase)
      BWP_IDLE: begin
        s_d.ctl.flow     = 1'b0;
        s_d.ctl.fetch_go = 1'b0;
      end
      BWP_WRITE: begin
        if (txn.phase) begin
          s_d.addr     = s_q.addr + 32'h1;
          s_d.line_cnt = at_line ? 11'h000 : s_q.line_cnt + 11'h001;
          // full buffer after this dword, or a boundary, ends the burst
          if (!txn.last && (wr_boundary || buf_st.pw_free_dw <= 11'h001)) begin
            s_d.ctl.disconnect = 1'b1;
            s_d.phase          = BWP_IDLE;
          end
        end
        if (txn.phase && txn.last) begin
          s_d.phase = BWP_IDLE;
        end
      end
      BWP_READ: begin
        // flow-through starts when the master draws data before a boundary
        if (buf_st.rd_taken && s_q.ctl.fetch_go && !s_q.ctl.flow) begin
          s_d.ctl.flow = 1'b1;
        end
        if (s_q.ctl.fetch_go && txn.phase) begin
          s_d.addr    = s_q.addr + 32'h1;
          s_d.fetched = s_q.fetched + 11'h001;
          if (s_q.ctl.flow) begin
            // single request lets the count go; only stop events end it
            if (stop_ev || (!buf_st.single_req
                            && s_q.fetched + 11'h001 >= s_q.ctl.pf_count)) begin
              s_d.ctl.fetch_go = 1'b0;
            end
          end else if (s_q.fetched + 11'h001 >= s_q.ctl.pf_count || stop_ev) begin
            s_d.ctl.fetch_go = 1'b0;
          end
        end
        if (txn.last) begin
          s_d.ctl.discard  = s_q.ctl.prefetch;
          s_d.ctl.fetch_go = 1'b0;
          s_d.phase        = BWP_IDLE;
        end
      end
      default: s_d.phase = BWP_IDLE;
    endcase

    // new address phase overrides what was in flight
    if (txn.start) begin
      s_d.cmd      = txn.cmd;
      s_d.upstream = txn.upstream;
      s_d.addr     = {2'h0, txn.addr[31:2]};
      s_d.line_cnt = cls_pow2 ? (txn.addr[12:2] & (cls_dw - 11'h001)) : 11'h000;
      s_d.fetched  = 11'h000;
      s_d.mwi_ok   = cls_pow2;
      s_d.ctl.flow = 1'b0;
      // a stale read classification must not follow into a write
      s_d.ctl.prefetch = 1'b0;
      s_d.ctl.all_be   = 1'b0;
      if (is_read) begin
        s_d.phase          = BWP_READ;
        s_d.ctl.prefetch   = is_pref && !txn.single_dw;
        s_d.ctl.all_be     = is_pref && !txn.single_dw;
        s_d.ctl.fetch_go   = 1'b1;
        s_d.ctl.pf_count   = (is_pref && !txn.single_dw) ? calc_cnt : 11'h001;
        s_d.ctl.retry      = 1'b1;
      end else if (txn.cmd == CMD_MEM_WRITE || txn.cmd == CMD_MEM_WINV) begin
        if (buf_st.pw_free_dw == 11'h000) begin
          s_d.ctl.retry = 1'b1;
          s_d.phase     = BWP_IDLE;
        end else begin
          s_d.ctl.accept = 1'b1;
          s_d.phase      = BWP_WRITE;
        end
      end else if (txn.cmd == CMD_IO_WRITE || txn.cmd == CMD_CFG_WRITE) begin
        s_d.ctl.retry  = 1'b1;
        s_d.ctl.accept = buf_st.dq_free && !(txn.fast_b2b && !buf_st.dq_free);
        s_d.phase      = BWP_IDLE;
      end else begin
        s_d.phase = BWP_IDLE;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      s_q       <= '0;
      s_q.cache_line_size   <= RST_CACHE_LINE_LENGTH;
      s_q.cbc   <= RST_CHIP_BEHAVIOUR;
      s_q.rfc   <= RST_READ_FETCH;
      s_q.phase <= BWP_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata    = s_q.rdata;
  assign avs_response    = s_q.resp;
  assign avs_waitrequest = !s_q.ack;
  assign ctl             = s_q.ctl;

endmodule // bwp_policy

// ==== testbench/bwp_far_model.sv ====
module bwp_far_model
  import bwp_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       go,
  input  wire bwp_txn_t   req,
  input  wire logic [7:0] nph,
  output bwp_txn_t        txn,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------
  // initiator: address phase, then back-to-back data phases
  // ------------------------------------------------
  logic [7:0] left = 8'h00;
  initial txn = '0;
  always @(posedge clock) begin
    if (go && left == 8'h00) begin
      txn  <= req;
      left <= nph;
    end else if (left != 8'h00) begin
      txn.start <= 1'b0;
      txn.phase <= 1'b1;
      txn.last  <= left == 8'h01;
      left      <= left - 8'h01;
    end else begin
      // released address lines keep moving so a stale value cannot look valid
      txn.start <= 1'b0;
      txn.phase <= 1'b0;
      txn.last  <= 1'b0;
      txn.addr  <= ~txn.addr;
    end
  end
  assign busy = txn.start || left != 8'h00;
endmodule // bwp_far_model

// ==== testbench/bwp_policy_props.sv ====
module bwp_policy_props
  import bwp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              clock,
  input wire logic              srst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic              avs_waitrequest,
  input wire bwp_txn_t          txn,
  input wire bwp_buf_t          buf_st,
  input wire bwp_ctl_t          ctl
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------
  // shadow of the settings and the burst address
  // ------------------------------------------------
  logic        disc_q;
  logic [7:0]  cls_q;
  logic [3:0]  cmd_q;
  logic [11:0] cur_q;
  wire logic   wr_ok = avs_write && !avs_waitrequest;
  always_ff @(posedge clock) begin
    if (srst) begin
      disc_q <= 1'b0;
      cls_q  <= 8'h00;
    end else if (wr_ok && avs_address == OFS_CACHE_LINE_LENGTH) begin
      cls_q <= avs_writedata[7:0];
    end else if (wr_ok && avs_address == OFS_CHIP_BEHAVIOUR_CONTROL) begin
      disc_q <= avs_writedata[CBC_WR_DISC_BIT];
    end
  end
  // the address of the dword in flight, counted here, not taken from the design
  always_ff @(posedge clock) begin
    cmd_q <= txn.start ? txn.cmd : cmd_q;
    cur_q <= txn.start ? txn.addr[11:0] : cur_q + {9'h000, txn.phase, 2'b00};
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  sequence s_wr_open(c);
    (cmd_q == CMD_MEM_WRITE || cmd_q == CMD_MEM_WINV) && txn.phase && !txn.last && c;
  endsequence
  AST_WR_4K: assert property (
    s_wr_open(cmd_q == CMD_MEM_WRITE && !disc_q && cur_q[11:2] == 10'h3FF)
    |=> ctl.disconnect) else $error("no disconnect at 4 kB boundary");
  AST_WINV_16: assert property (
    s_wr_open(cmd_q == CMD_MEM_WINV && cls_q == 8'h10 && cur_q[5:2] == 4'hF)
    |=> ctl.disconnect) else $error("no disconnect at 16 dword line");
  AST_FULL: assert property (
    s_wr_open(buf_st.pw_free_dw <= 11'h001) |=> ctl.disconnect)
    else $error("no disconnect on full buffer");
  AST_DQ_FULL: assert property (
    txn.start && txn.cmd == CMD_IO_WRITE && !buf_st.dq_free |=> !ctl.accept)
    else $error("delayed write taken with full queue");
  AST_B2B: assert property (
    txn.start && txn.fast_b2b && txn.cmd == CMD_MEM_WRITE && buf_st.pw_free_dw == 11'h000
    |=> ctl.retry && !ctl.accept) else $error("fast back to back not retried");
  AST_NO_PF: assert property (
    txn.start && (txn.cmd == CMD_IO_READ || txn.cmd == CMD_CFG_READ) |=> !ctl.prefetch)
    else $error("io or config read prefetched");
  AST_DISCARD: assert property (
    !cmd_q[0] && txn.phase && txn.last && ctl.prefetch |=> ctl.discard)
    else $error("no discard at read end");
  AST_LINE_PF: assert property (
    txn.start && (txn.cmd == CMD_MEM_RLINE || txn.cmd == CMD_MEM_RMULT) && !txn.single_dw
    |=> ctl.prefetch) else $error("line or multiple read not prefetched");
  AST_MIN16: assert property (
    ctl.prefetch |-> ctl.pf_count >= MIN_PREFETCH_DW) else $error("prefetch count under 16");
  AST_SINGLE: assert property (
    txn.start && !txn.cmd[0] && txn.single_dw |=> !ctl.prefetch)
    else $error("single dword read prefetched");
endmodule // bwp_policy_props

bind bwp_policy bwp_policy_props #(.ADDR_W(ADDR_W)) u_props (
  .clock(clock), .srst(srst), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest), .txn(txn),
  .buf_st(buf_st), .ctl(ctl));

// ==== testbench/bwp_policy_tb_top.sv ====
module bwp_policy_tb_top
  import bwp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------
  // stimulus, monitor and checks
  // ------------------------------------------------
  // row: cmd, upstream, in range, single dword, prefetch expected
  logic [7:0]  rows [8] = '{8'h20, 8'hA0, 8'h65, 8'h60, 8'h69, 8'hE1, 8'hC1, 8'hC2};
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  bwp_txn_t    txn;
  bwp_txn_t    req = '0;
  bwp_buf_t    buf_st = '{pw_free_dw: 11'h200, dq_free: 1'b1, default: 1'b0};
  bwp_ctl_t    ctl;
  logic        go = 1'b0;
  logic        busy;
  logic        mon = 1'b0;
  logic        pf_any;
  logic [7:0]  nph = 8'h01;
  logic [31:0] rdat;
  logic [1:0]  rsp;
  int          cnt [4];
  int          failures = 0;
  int          checked = 0;
  initial begin
    forever #5 clock = ~clock;
  end
  bwp_policy #(.ADDR_W(8)) dut (.clock(clock), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .txn(txn), .buf_st(buf_st), .ctl(ctl));
  bwp_far_model u_far (.clock(clock), .go(go), .req(req), .nph(nph), .txn(txn), .busy(busy));
  always @(posedge clock) begin
    if (mon) begin
      cnt[0] += (ctl.disconnect === 1'b1);
      cnt[1] += (ctl.retry === 1'b1);
      cnt[2] += (ctl.accept === 1'b1);
      cnt[3] += (ctl.discard === 1'b1);
      pf_any = pf_any | (txn.phase & ctl.prefetch);
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clock);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    failures += (t >= 50);
    rdat = avs_readdata;
    rsp  = avs_response;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clock);
  endtask
  // fl: upstream, fast back-to-back, in range, single dword
  task automatic run(input logic [3:0] c, input logic [11:0] a, input logic [7:0] n,
                     input logic [3:0] fl);
    int t;
    t = 0;
    req <= {1'b1, c, 20'h00000, a, fl, 2'b00};
    nph <= n;
    go  <= 1'b1;
    cnt = '{default: 0};
    pf_any = 1'b0;
    mon = 1'b1;
    @(posedge clock);
    go <= 1'b0;
    do begin
      @(posedge clock);
      t++;
    end while (busy && t < 100);
    failures += (t >= 100);
    repeat (2) @(posedge clock);
    mon = 1'b0;
  endtask
  task automatic wrap_up();
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // the whole run is well under a thousand cycles; this leaves ample margin
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    bus(1'b0, OFS_CACHE_LINE_LENGTH, 32'h0);
    chk("cache_line_length", rdat, {24'h0, RST_CACHE_LINE_LENGTH});
    bus(1'b0, OFS_CHIP_BEHAVIOUR_CONTROL, 32'h0);
    chk("chip_behaviour_control", rdat, {24'h0, RST_CHIP_BEHAVIOUR});
    bus(1'b0, OFS_READ_FETCH_CONTROL, 32'h0);
    chk("read_fetch_control", rdat, {24'h0, RST_READ_FETCH});
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped response", {30'h0, rsp}, 32'h2);
    foreach (rows[i]) begin
      run(rows[i][7:4], 12'h000, 8'h01, {rows[i][3], 1'b0, rows[i][2:1]});
      chk("prefetch", {31'h0, pf_any}, {31'h0, rows[i][0]});
      chk("discard", cnt[3], {31'h0, rows[i][0]});
    end
    bus(1'b1, OFS_CACHE_LINE_LENGTH, 32'h00000003);
    bus(1'b1, OFS_READ_FETCH_CONTROL, 32'h00000030);
    run(CMD_MEM_RLINE, 12'h000, 8'h01, 4'b0000);
    bus(1'b0, OFS_PREFETCH_COUNT, 32'h0);
    chk("prefetch count", {21'h0, rdat[10:0]}, {21'h0, 11'h009 + ALIGN16_DW});
    bus(1'b1, OFS_READ_FETCH_CONTROL, 32'h0000000E);
    run(CMD_MEM_READ, 12'h000, 8'h01, 4'b1000);
    chk("upstream prefetch off", {31'h0, pf_any}, 32'h0);
    run(CMD_MEM_WRITE, 12'hFF8, 8'h03, 4'b0000);
    chk("disconnect at 4 kB", cnt[0], 32'h1);
    chk("write accept", cnt[2], 32'h1);
    bus(1'b1, OFS_CACHE_LINE_LENGTH, 32'h10);
    run(CMD_MEM_WINV, 12'h038, 8'h03, 4'b0000);
    chk("disconnect at line", cnt[0], 32'h1);
    buf_st.pw_free_dw <= 11'h001;
    run(CMD_MEM_WRITE, 12'h100, 8'h02, 4'b0000);
    chk("disconnect when full", cnt[0], 32'h1);
    chk("accept with one dword", cnt[2], 32'h1);
    buf_st.pw_free_dw <= 11'h000;
    run(CMD_MEM_WRITE, 12'h200, 8'h01, 4'b0100);
    chk("fast b2b retry", cnt[1], 32'h1);
    chk("fast b2b accept", cnt[2], 32'h0);
    buf_st.dq_free <= 1'b0;
    run(CMD_IO_WRITE, 12'h300, 8'h01, 4'b0000);
    chk("delayed write accept", cnt[2], 32'h0);
    buf_st <= '{pw_free_dw: 11'h200, dq_free: 1'b1, default: 1'b0};
    run(CMD_CFG_WRITE, 12'h300, 8'h01, 4'b0000);
    chk("delayed write retry", cnt[1], 32'h1);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    bus(1'b0, OFS_READ_FETCH_CONTROL, 32'h0);
    chk("read_fetch_control again", rdat, {24'h0, RST_READ_FETCH});
    wrap_up();
  end
endmodule // bwp_policy_tb_top
